/* src/tcc_pkg.sv */
package tcc_pkg;
  localparam logic [6:0]  DEV_ID         = 7'h6f;
  localparam logic [7:0]  ADDR_CTRL      = 8'h20;
  localparam logic [7:0]  ADDR_INIT_TRIM = 8'h21;
  localparam logic [7:0]  ADDR_INIT_SCL  = 8'h22;
  localparam logic [7:0]  ADDR_COLD      = 8'h23;
  localparam logic [7:0]  ADDR_TEMP_LOW  = 8'h28;
  localparam logic [7:0]  ADDR_TEMP_HIGH = 8'h29;
  localparam logic [7:0]  ADDR_NET_LOW   = 8'h2a;
  localparam logic [7:0]  ADDR_NET_HIGH  = 8'h2b;
  localparam logic [7:0]  ADDR_TURNOVER  = 8'h2c;
  localparam logic [7:0]  ADDR_HOT       = 8'h2d;
  localparam logic [7:0]  ADDR_LAST      = 8'h2f;
  localparam int          CTRL_TSE_BIT   = 0;
  localparam int          TURN_SIGN_BIT  = 4;
  localparam logic [9:0]  TURNOVER_BASE  = 10'h254;
  localparam logic [9:0]  TEMP_CODE_MIN  = 10'h1be;
  localparam logic [9:0]  TEMP_CODE_MAX  = 10'h2d6;
  localparam logic [9:0]  TEMP_CODE_RST  = 10'h254;
  localparam int          THERM_SHIFT    = 12;
  localparam logic [15:0] DIG_TRIM_BIAS  = 16'h0010;
  localparam logic [4:0]  TURNOVER_RST   = 5'h00;
  localparam logic [6:0]  HOT_RST        = 7'h00;
  localparam logic [6:0]  COLD_RST       = 7'h00;
  localparam logic [5:0]  INIT_TRIM_RST  = 6'h00;
  localparam logic [4:0]  INIT_SCL_RST   = 5'h00;
  localparam logic        TSE_RST        = 1'b0;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          CONV_PERIOD_MS = 500;
  localparam int          CONV_CYCLES    = CONV_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
endpackage

/* src/tcc_temp_comp.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Temperature code is ten bits, twice kelvin
// RULE_02 - Low byte bits 7:0, high byte bits 9:8
// RULE_03 - Reported code averages two successive conversions
// RULE_04 - Software: celsius equals code halved minus 273
// RULE_05 - Code stays between 446 and 726
// RULE_06 - Convert only while sense enable is one
// RULE_07 - Net correction is twice the ppm correction
// RULE_08 - Net equals initial plus thermal correction
// RULE_09 - Thermal: coefficient times delta squared over 4096
// RULE_10 - Hot coefficient at or above turnover, else cold
// RULE_11 - Turnover reference is 596 plus setting
// RULE_12 - Coefficients are magnitude times 2048, seven bits
// RULE_13 - Turnover setting is sign magnitude half degrees
// RULE_14 - Turnover preset recalled at power-up, read only
// RULE_15 - Hot coefficient preset recalled, read only
// RULE_16 - Net matches twice scale times trim minus digital
// RULE_17 - Serial slave, word address, auto increment
// RULE_18 - Recompute net on each new averaged code
module tcc_temp_comp #(
  parameter int CONV_CYCLES = tcc_pkg::CONV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output wire logic        sda_out,
  output wire logic        sda_oe_n,
  input  wire logic [4:0]  preset_turnover,
  input  wire logic [6:0]  preset_hot,
  output wire logic        conv_req,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_code,
  output wire logic [15:0] osc_trim,
  output wire logic [5:0]  analog_trim,
  output wire logic [15:0] digital_trim
);

  typedef enum logic [3:0] {
    TCC_IDLE, TCC_DEV, TCC_ACK_DEV, TCC_WADDR, TCC_ACK_ADDR,
    TCC_WDATA, TCC_ACK_WR, TCC_RDATA, TCC_RACK
  } tcc_bus_type;

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    tcc_bus_type st;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        rw;
    logic [7:0]  ptr;
    logic        drv;
    logic        temp_sense_enable;
    logic [5:0]  init_trim;
    logic [4:0]  init_scale;
    logic [6:0]  cold;
    logic [4:0]  turnover;
    logic [6:0]  hot;
    logic        recalled;
    logic [23:0] conv_cnt;
    logic        conv_req;
    logic        half;
    logic [9:0]  first_code;
    logic [9:0]  temp_code;
    logic [15:0] net;
    logic [15:0] dig_trim;
  } tcc_state_type;

  tcc_state_type st_r;
  tcc_state_type st_nxt;

  // Pointer wraps from the last register back to zero
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = (p >= tcc_pkg::ADDR_LAST) ? 8'h00 : p + 8'h01; // RULE_17
  endfunction

  // Unmapped addresses read as zero
  function automatic logic [7:0] read_reg(input tcc_state_type s, input logic [7:0] a);
    case (a)
      tcc_pkg::ADDR_CTRL:      read_reg = {7'h00, s.temp_sense_enable};
      tcc_pkg::ADDR_INIT_TRIM: read_reg = {2'h0, s.init_trim};
      tcc_pkg::ADDR_INIT_SCL:  read_reg = {3'h0, s.init_scale};
      tcc_pkg::ADDR_COLD:      read_reg = {1'h0, s.cold};
      tcc_pkg::ADDR_TEMP_LOW:  read_reg = s.temp_code[7:0]; // RULE_02
      tcc_pkg::ADDR_TEMP_HIGH: read_reg = {6'h00, s.temp_code[9:8]}; // RULE_02
      tcc_pkg::ADDR_NET_LOW:   read_reg = s.net[7:0];
      tcc_pkg::ADDR_NET_HIGH:  read_reg = s.net[15:8];
      tcc_pkg::ADDR_TURNOVER:  read_reg = {3'h0, s.turnover};
      tcc_pkg::ADDR_HOT:       read_reg = {1'h0, s.hot};
      default:                 read_reg = 8'h00;
    endcase
  endfunction

  logic               scl_rise;
  logic               scl_fall;
  logic               bus_start;
  logic               bus_stop;
  logic [7:0]         rd_byte;
  logic [9:0]         sum_half;
  logic [10:0]        avg_sum;
  logic [9:0]         avg_code;
  logic signed [10:0] t0;
  logic signed [10:0] dt;
  logic [21:0]        sq;
  logic [6:0]         alpha;
  logic [28:0]        prod;
  logic signed [15:0] therm;
  logic signed [15:0] initial_corr;
  logic signed [15:0] net_new;
  logic signed [15:0] scale_trim;

  always_comb
  begin
    st_nxt = st_r;
    // Two flops synchronise the pins; the third only serves edge detection
    st_nxt.scl_s1 = scl_in;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.scl_s3 = st_r.scl_s2;
    st_nxt.sda_s1 = sda_in;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.sda_s3 = st_r.sda_s2;
    // START and STOP are SDA edges while SCL stays high
    scl_rise  = st_r.scl_s2 & ~st_r.scl_s3;
    scl_fall  = ~st_r.scl_s2 & st_r.scl_s3;
    bus_start = st_r.scl_s2 & st_r.scl_s3 & ~st_r.sda_s2 & st_r.sda_s3;
    bus_stop  = st_r.scl_s2 & st_r.scl_s3 & st_r.sda_s2 & ~st_r.sda_s3;
    rd_byte   = read_reg(st_r, st_r.ptr);

    // Presets load once on the first edge after reset release
    if (!st_r.recalled)
    begin
      st_nxt.recalled = 1'b1;
      st_nxt.turnover = preset_turnover; // RULE_14
      st_nxt.hot      = preset_hot; // RULE_15
    end

    // Serial register port
    if (bus_start)
    begin
      st_nxt.st      = TCC_DEV;
      st_nxt.bit_cnt = 4'h0;
      st_nxt.drv     = 1'b0;
    end
    else if (bus_stop)
    begin
      st_nxt.st  = TCC_IDLE;
      st_nxt.drv = 1'b0;
    end
    else
    begin
      unique case (st_r.st)
        TCC_IDLE: ;
        TCC_DEV, TCC_WADDR, TCC_WDATA:
        begin
          if (scl_rise)
          begin
            st_nxt.shift   = {st_r.shift[6:0], st_r.sda_s2};
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          end
          else if (scl_fall && st_r.bit_cnt == 4'h8)
          begin
            st_nxt.drv = 1'b1;
            if (st_r.st == TCC_DEV)
            begin
              if (st_r.shift[7:1] == tcc_pkg::DEV_ID) // RULE_17
              begin
                st_nxt.rw = st_r.shift[0];
                st_nxt.st = TCC_ACK_DEV;
              end
              else
              begin
                st_nxt.drv = 1'b0;
                st_nxt.st  = TCC_IDLE;
              end
            end
            else if (st_r.st == TCC_WADDR)
            begin
              st_nxt.ptr = st_r.shift; // RULE_17
              st_nxt.st  = TCC_ACK_ADDR;
            end
            else
            begin
              // Only the control, trim, scale and cold registers take writes
              unique case (st_r.ptr)
                tcc_pkg::ADDR_CTRL:      st_nxt.temp_sense_enable = st_r.shift[tcc_pkg::CTRL_TSE_BIT];
                tcc_pkg::ADDR_INIT_TRIM: st_nxt.init_trim = st_r.shift[5:0];
                tcc_pkg::ADDR_INIT_SCL:  st_nxt.init_scale = st_r.shift[4:0];
                tcc_pkg::ADDR_COLD:      st_nxt.cold = st_r.shift[6:0];
                default: ; // RULE_14 RULE_15
              endcase
              st_nxt.ptr = next_ptr(st_r.ptr); // RULE_17
              st_nxt.st  = TCC_ACK_WR;
            end
          end
        end
        TCC_ACK_DEV, TCC_ACK_ADDR, TCC_ACK_WR:
        begin
          if (scl_fall)
          begin
            st_nxt.bit_cnt = 4'h0;
            st_nxt.drv     = 1'b0;
            // Read: the first data bit goes out on the falling edge ending the ack
            if (st_r.st == TCC_ACK_DEV && st_r.rw)
            begin
              st_nxt.shift   = rd_byte;
              st_nxt.drv     = ~rd_byte[7];
              st_nxt.bit_cnt = 4'h1;
              st_nxt.ptr     = next_ptr(st_r.ptr); // RULE_17
              st_nxt.st      = TCC_RDATA;
            end
            else if (st_r.st == TCC_ACK_DEV)
              st_nxt.st = TCC_WADDR;
            else
              st_nxt.st = TCC_WDATA;
          end
        end
        TCC_RDATA:
        begin
          if (scl_fall)
          begin
            if (st_r.bit_cnt == 4'h8)
            begin
              st_nxt.drv = 1'b0;
              st_nxt.st  = TCC_RACK;
            end
            else
            begin
              st_nxt.shift   = {st_r.shift[6:0], 1'b0};
              st_nxt.drv     = ~st_r.shift[6];
              st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
            end
          end
        end
        TCC_RACK:
        begin
          // Master NACK ends the read; an ACK fetches the next byte
          if (scl_rise && st_r.sda_s2)
            st_nxt.st = TCC_IDLE;
          else if (scl_fall)
          begin
            st_nxt.shift   = rd_byte;
            st_nxt.drv     = ~rd_byte[7];
            st_nxt.bit_cnt = 4'h1;
            st_nxt.ptr     = next_ptr(st_r.ptr); // RULE_17
            st_nxt.st      = TCC_RDATA;
          end
        end
      endcase
    end

    // Conversion scheduling
    // Clearing the enable drops a half-done pair, so no stale reading is averaged
    st_nxt.conv_req = 1'b0;
    if (!st_r.temp_sense_enable)
    begin
      st_nxt.conv_cnt = 24'h000000; // RULE_06
      st_nxt.half     = 1'b0;
    end
    else if (st_r.conv_cnt >= 24'(CONV_CYCLES - 1))
    begin
      st_nxt.conv_cnt = 24'h000000;
      st_nxt.conv_req = 1'b1; // RULE_06
    end
    else
      st_nxt.conv_cnt = st_r.conv_cnt + 24'h000001;

    // Averaging, clamping and correction datapath
    sum_half = (conv_code < tcc_pkg::TEMP_CODE_MIN) ? tcc_pkg::TEMP_CODE_MIN :
               (conv_code > tcc_pkg::TEMP_CODE_MAX) ? tcc_pkg::TEMP_CODE_MAX : conv_code; // RULE_05
    avg_sum  = {1'b0, st_r.first_code} + {1'b0, sum_half};
    avg_code = avg_sum[10:1]; // RULE_01 RULE_03
    // Setting bit four moves the turnover below the base
    t0 = $signed({1'b0, tcc_pkg::TURNOVER_BASE}) +
         (st_r.turnover[tcc_pkg::TURN_SIGN_BIT] ? -$signed({7'h00, st_r.turnover[3:0]})
                                                 : $signed({7'h00, st_r.turnover[3:0]})); // RULE_11 RULE_13
    dt    = $signed({1'b0, avg_code}) - t0;
    // Delta spans roughly -165 to +145 codes
    sq    = 22'(dt * dt);
    alpha = ($signed({1'b0, avg_code}) >= t0) ? st_r.hot : st_r.cold; // RULE_10 RULE_12
    prod  = 29'({7'h00, sq} * {22'h000000, alpha});
    // Square stays under 2**15 and the product under 2**22, so the shifted value fits in 10 of the 15 bits
    therm = $signed({1'b0, prod[26:tcc_pkg::THERM_SHIFT]}); // RULE_09
    // Signed trim times scale stays well inside 16 bits
    scale_trim   = $signed({11'h000, st_r.init_scale}) * $signed({{10{st_r.init_trim[5]}}, st_r.init_trim});
    initial_corr = 16'(scale_trim <<< 1); // RULE_07 RULE_16
    net_new      = initial_corr + therm; // RULE_08

    // Two accepted results make one reported code
    if (st_r.temp_sense_enable && conv_done)
    begin
      if (!st_r.half)
      begin
        st_nxt.first_code = sum_half;
        st_nxt.half       = 1'b1;
      end
      else
      begin
        st_nxt.half      = 1'b0;
        st_nxt.temp_code = avg_code; // RULE_03
        st_nxt.net       = net_new; // RULE_18
        // Chosen so that twice (scale*trim - (digital - 16)) equals the net value with bit 0 cleared
        st_nxt.dig_trim  = tcc_pkg::DIG_TRIM_BIAS + 16'(scale_trim) - 16'(net_new >>> 1); // RULE_16
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r            <= '0;
      // Pins idle high, so the edge detectors start high and see no false START
      st_r.scl_s1     <= 1'b1;
      st_r.scl_s2     <= 1'b1;
      st_r.scl_s3     <= 1'b1;
      st_r.sda_s1     <= 1'b1;
      st_r.sda_s2     <= 1'b1;
      st_r.sda_s3     <= 1'b1;
      st_r.st         <= TCC_IDLE;
      st_r.temp_sense_enable        <= tcc_pkg::TSE_RST;
      st_r.init_trim  <= tcc_pkg::INIT_TRIM_RST;
      st_r.init_scale <= tcc_pkg::INIT_SCL_RST;
      st_r.cold       <= tcc_pkg::COLD_RST;
      st_r.turnover   <= tcc_pkg::TURNOVER_RST;
      st_r.hot        <= tcc_pkg::HOT_RST;
      st_r.temp_code  <= tcc_pkg::TEMP_CODE_RST;
      st_r.dig_trim   <= tcc_pkg::DIG_TRIM_BIAS;
    end
    else
      st_r <= st_nxt;
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out      = 1'b0;
  assign sda_oe_n     = ~st_r.drv;
  assign conv_req     = st_r.conv_req;
  assign osc_trim     = st_r.net;
  assign analog_trim  = st_r.init_trim;
  assign digital_trim = st_r.dig_trim;

endmodule

/* verification/tcc_temp_comp_properties.sv */
`timescale 1ns/1ps
module tcc_temp_comp_properties #(
  parameter int CONV_CYCLES = tcc_pkg::CONV_CYCLES
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic [4:0]  preset_turnover,
  input wire logic [6:0]  preset_hot,
  input wire logic        conv_req,
  input wire logic        conv_done,
  input wire logic [9:0]  conv_code,
  input wire logic [15:0] osc_trim,
  input wire logic [5:0]  analog_trim,
  input wire logic [15:0] digital_trim
);
  logic [31:0] gap_r;
  logic [1:0]  dcnt_r;
  logic [15:0] prev_r;
  // Cycles since the last request; result pulses since the correction last moved
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap_r  <= 32'h0;
      dcnt_r <= 2'h0;
      prev_r <= 16'h0;
    end
    else
    begin
      gap_r  <= conv_req ? 32'h1 : gap_r + 32'h1;
      dcnt_r <= (osc_trim != prev_r) ? {1'b0, conv_done} : dcnt_r + {1'b0, conv_done && dcnt_r != 2'h3};
      prev_r <= osc_trim;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_sda_out_low;
    sda_out == 1'b0;
  endproperty
  a_sda_out_low: assert property (p_sda_out_low) else $error("sda_out not low");
  property p_sda_scl_low;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved while scl high");
  property p_req_pulse;
    conv_req |=> !conv_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("conv_req longer than one cycle");
  property p_req_gap;
    conv_req |-> gap_r >= CONV_CYCLES;
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("conv_req too early");
  property p_req_quiet;
    $fell(sys_rst) |-> !conv_req [*8];
  endproperty
  a_req_quiet: assert property (p_req_quiet) else $error("conv_req with sensing off");
  property p_reset_vals;
    $fell(sys_rst) |-> osc_trim == 16'h0000 && digital_trim == 16'h0010 && analog_trim == 6'h00 && sda_oe_n;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
  property p_net_after_done;
    $changed(osc_trim) |-> $past(conv_done);
  endproperty
  a_net_after_done: assert property (p_net_after_done) else $error("net moved without result");
  property p_net_two_done;
    $changed(osc_trim) |-> dcnt_r >= 2'h2;
  endproperty
  a_net_two_done: assert property (p_net_two_done) else $error("net moved after one conversion");
endmodule
bind tcc_temp_comp tcc_temp_comp_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (.clk(clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .preset_turnover(preset_turnover),
  .preset_hot(preset_hot), .conv_req(conv_req), .conv_done(conv_done), .conv_code(conv_code),
  .osc_trim(osc_trim), .analog_trim(analog_trim), .digital_trim(digital_trim));

/* verification/tcc_temp_comp_tb.sv */
`timescale 1ns/1ps
module tcc_temp_comp_tb;
  localparam int         CC   = 8;
  localparam logic [4:0] TURN = 5'h13;
  localparam logic [6:0] HOT  = 7'h46;
  logic        clk = 1'b0, sys_rst = 1'b1, m_scl = 1'b1, m_sda = 1'b1, conv_done = 1'b0;
  logic [9:0]  conv_code = 10'h000;
  logic        sda_out, sda_oe_n, conv_req, seen;
  logic [15:0] osc_trim, digital_trim;
  logic [5:0]  analog_trim;
  logic [7:0]  d0, d1;
  int          n_errors = 0, n_checks = 0, cyc = 0;
  // Open-drain bus with pull-up
  wire         sda_w = m_sda & (sda_oe_n | sda_out);
  tcc_temp_comp #(.CONV_CYCLES(CC)) i_dut (.clk(clk), .sys_rst(sys_rst), .scl_in(m_scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .preset_turnover(TURN), .preset_hot(HOT), .conv_req(conv_req),
    .conv_done(conv_done), .conv_code(conv_code), .osc_trim(osc_trim), .analog_trim(analog_trim),
    .digital_trim(digital_trim));
  always #50 clk = ~clk;
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    m_sda = b;
    w(8);
    m_scl = 1'b1;
    w(8);
    r = sda_w;
    m_scl = 1'b0;
    w(8);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(ma, a);
  endtask
  task automatic start();
    m_sda = 1'b1;
    w(8);
    m_scl = 1'b1;
    w(8);
    m_sda = 1'b0;
    w(8);
    m_scl = 1'b0;
    w(8);
  endtask
  task automatic stop();
    m_sda = 1'b0;
    w(8);
    m_scl = 1'b1;
    w(8);
    m_sda = 1'b1;
    w(8);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer(8'hde, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    xfer(v, 1'b1, q, k2);
    chk({k0, k1, k2}, 16'h0000);
    stop();
  endtask
  // Two-byte read from address a into d0, d1
  task automatic rd(input logic [7:0] a);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer(8'hde, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    start();
    xfer(8'hdf, 1'b1, q, k2);
    chk({k0, k1, k2}, 16'h0000);
    xfer(8'hff, 1'b0, d0, k0);
    xfer(8'hff, 1'b1, d1, k0);
    stop();
  endtask
  function automatic int net(input int c, input int sc, input int tr, input int cold);
    int t0;
    t0 = 596 + (TURN[4] ? -int'(TURN[3:0]) : int'(TURN[3:0]));
    return 2 * sc * tr + ((c >= t0 ? int'(HOT) : cold) * (c - t0) * (c - t0)) / 4096;
  endfunction
  function automatic int cl(input int x);
    return x < 446 ? 446 : (x > 726 ? 726 : x);
  endfunction
  initial
  begin
    static int ta [3] = '{700, 450, 300};
    static int tb [3] = '{701, 451, 800};
    int c;
    int n;
    w(16);
    sys_rst = 1'b0;
    w(6);
    chk(osc_trim, 16'h0000);
    chk(digital_trim, 16'h0010);
    rd(8'h28);
    chk({d1, d0}, 16'h0254);
    chk(16'(({d1, d0} >> 1) - 16'h0111), 16'h0019);
    $display("Test reset values done");
    wr(8'h2c, 8'h1f);
    wr(8'h2d, 8'h11);
    rd(8'h2c);
    chk(d0, {3'h0, TURN});
    chk(d1, {1'b0, HOT});
    rd(8'h2f);
    chk({d0, d1}, 16'h0000);
    start();
    xfer(8'hd0, 1'b1, d0, seen);
    chk(seen, 1'b1);
    stop();
    $display("Test presets and addressing done");
    wr(8'h21, 8'h3e);
    wr(8'h22, 8'h03);
    wr(8'h23, 8'h28);
    wr(8'h20, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      seen = 1'b0;
      for (int k = 0; k < 4 * CC && !seen; k++)
      begin
        w(1);
        seen = conv_req;
      end
      chk(seen, 1'b1);
      conv_code = 10'(ta[i]);
      conv_done = 1'b1;
      w(1);
      conv_done = 1'b0;
      w(3);
      conv_code = 10'(tb[i]);
      conv_done = 1'b1;
      w(1);
      conv_done = 1'b0;
      w(3);
      c = (cl(ta[i]) + cl(tb[i])) / 2;
      n = net(c, 3, -2, 40);
      chk(osc_trim, 16'(n));
      chk(digital_trim, 16'(16 + 3 * (-2) - (n >>> 1)));
      chk(analog_trim, 6'h3e);
      rd(8'h28);
      chk({d1, d0}, 16'(c));
      rd(8'h2a);
      chk({d1, d0}, 16'(n));
    end
    $display("Test compensation done");
    wr(8'h20, 8'h00);
    seen = 1'b0;
    repeat (4 * CC)
    begin
      w(1);
      seen = seen | conv_req;
    end
    chk(seen, 1'b0);
    // A full pair that would move the correction if it were taken
    conv_code = 10'(ta[0]);
    repeat (2)
    begin
      conv_done = 1'b1;
      w(1);
      conv_done = 1'b0;
      w(3);
    end
    chk(osc_trim, 16'(n));
    $display("Test sensing disabled done");
    results();
  end
endmodule
